// ---- core/rlh_defs.svh ----
`ifndef RLH_DEFS_SVH
`define RLH_DEFS_SVH
// ****************************************
// register offsets
// ****************************************
`define RLH_OFS_CTRL    8'h00
`define RLH_OFS_HSHAKE  8'h04
`define RLH_OFS_PERIOD  8'h08
`define RLH_OFS_FN_ACT  8'h0c
`define RLH_OFS_FN_CTL  8'h10
`define RLH_OFS_STATUS  8'h14
`define RLH_OFS_IRQ_ST  8'h18
`define RLH_OFS_IRQ_CLR 8'h1c
`define RLH_OFS_IRQ_EN  8'h20
// ****************************************
// fields and reset values
// ****************************************
`define RLH_CTRL_MODE   0
`define RLH_CTRL_ACT    1
`define RLH_IRQ_FAULT   0
`define RLH_IRQ_HS      1
`define RLH_IRQ_BADPER  2
`define RLH_PERIOD_MIN  14'h000a
`define RLH_PERIOD_MAX  14'h2706
`define RLH_PERIOD_RST  14'h000a
// ****************************************
// timing
// ****************************************
`define RLH_CLK_NS      50
`define RLH_TICK_NS     1000000000
`endif

// ---- core/rlh_pkg.sv ----
package rlh_pkg;
	typedef enum logic [1:0] {RLH_IDLE, RLH_RUN, RLH_FAULT} rlh_state_t;
	typedef struct packed {
		rlh_state_t  st;
		logic        awv;
		logic [7:0]  awaddr;
		logic        wv;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic        mode;
		logic        act;
		logic        hs;
		logic [13:0] period;
		logic [13:0] timer;
		logic [31:0] tcnt;
		logic [15:0] fn_act;
		logic [15:0] fn_ctl;
		logic [15:0] fn_remote;
		logic [15:0] fn_val;
		logic        fault;
		logic [2:0]  irq_st;
		logic [2:0]  irq_en;
		logic        irq;
	} rlh_regs_t;
endpackage

// ---- core/rlh_monitor.sv ----
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`include "rlh_defs.svh"
module rlh_monitor
	import rlh_pkg::*;
#(
	parameter int NFUNC       = 8,
	parameter int TICK_CYCLES = `RLH_TICK_NS / `RLH_CLK_NS
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	// axi4-lite write
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	// axi4-lite read
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [7:0]        s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	// function control
	output logic [NFUNC-1:0]       fn_remote,
	output logic [NFUNC-1:0]       fn_value,
	output logic                   link_fault,
	output logic                   irq
);
	// refuse sizes the logic cannot serve
	if (NFUNC < 1 || NFUNC > 16 || TICK_CYCLES < 2) begin : g_bad_param
		$error("rlh_monitor: unsupported parameters");
	end

	rlh_regs_t r_ff;
	rlh_regs_t nxt_r;

	logic        sup;
	logic        tick;
	logic        wr_go;
	logic        hs_set;
	logic [31:0] wmask;

	function automatic logic [31:0] rlh_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [31:0] m);
		rlh_merge = (old & ~m) | (nw & m);
	endfunction

	// ****************************************
	// byte lane mask
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wmask[gi*8 +: 8] = {8{r_ff.wstrb[gi]}};
		end
	endgenerate

	assign sup    = r_ff.mode & r_ff.act;
	assign tick   = r_ff.tcnt == 32'(TICK_CYCLES - 1);
	assign wr_go  = r_ff.awv & r_ff.wv & ~r_ff.bvalid;
	assign hs_set = wr_go && r_ff.awaddr == `RLH_OFS_HSHAKE && r_ff.wstrb[0] && r_ff.wdata[0];

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [31:0] v;
		v = 32'h0000_0000;
		nxt_r = r_ff;
		// bus handshakes
		if (r_ff.bvalid && s_axi_bready)
			nxt_r.bvalid = 1'b0;
		if (r_ff.rvalid && s_axi_rready)
			nxt_r.rvalid = 1'b0;
		if (s_axi_awvalid && r_ff.awready) begin
			nxt_r.awv    = 1'b1;
			nxt_r.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && r_ff.wready) begin
			nxt_r.wv    = 1'b1;
			nxt_r.wdata = s_axi_wdata;
			nxt_r.wstrb = s_axi_wstrb;
		end
		// register writes
		// remote control data
		if (wr_go) begin
			nxt_r.awv    = 1'b0;
			nxt_r.wv     = 1'b0;
			nxt_r.bvalid = 1'b1;
			nxt_r.bresp  = 2'h0;
			v = rlh_merge(32'h0000_0000, r_ff.wdata, wmask);
			case (r_ff.awaddr)
				`RLH_OFS_CTRL: begin
					if (r_ff.wstrb[0]) begin
						nxt_r.mode = r_ff.wdata[`RLH_CTRL_MODE];
						nxt_r.act  = r_ff.wdata[`RLH_CTRL_ACT];
					end
				end
				`RLH_OFS_HSHAKE: ;
				`RLH_OFS_PERIOD: begin
					v = rlh_merge({18'h00000, r_ff.period}, r_ff.wdata, wmask);
					if (v[13:0] >= `RLH_PERIOD_MIN && v[13:0] <= `RLH_PERIOD_MAX && v[31:14] == 18'h00000)
						nxt_r.period = v[13:0];
					else
						nxt_r.irq_st[`RLH_IRQ_BADPER] = 1'b1;
				end
				`RLH_OFS_FN_ACT: nxt_r.fn_act = 16'(rlh_merge({16'h0000, r_ff.fn_act}, r_ff.wdata, wmask));
				`RLH_OFS_FN_CTL: nxt_r.fn_ctl = 16'(rlh_merge({16'h0000, r_ff.fn_ctl}, r_ff.wdata, wmask));
				`RLH_OFS_STATUS, `RLH_OFS_IRQ_ST: ;
				`RLH_OFS_IRQ_CLR: nxt_r.irq_st = r_ff.irq_st & ~v[2:0];
				`RLH_OFS_IRQ_EN: begin
					if (r_ff.wstrb[0])
						nxt_r.irq_en = r_ff.wdata[2:0];
				end
				default: nxt_r.bresp = 2'h2;
			endcase
		end
		// register reads
		if (s_axi_arvalid && r_ff.arready) begin
			nxt_r.rvalid = 1'b1;
			nxt_r.rresp  = 2'h0;
			case (s_axi_araddr)
				`RLH_OFS_CTRL:    nxt_r.rdata = {30'h0, r_ff.act, r_ff.mode};
				`RLH_OFS_HSHAKE:  nxt_r.rdata = {31'h0, r_ff.hs};
				`RLH_OFS_PERIOD:  nxt_r.rdata = {18'h0, r_ff.period};
				`RLH_OFS_FN_ACT:  nxt_r.rdata = {16'h0, r_ff.fn_act};
				`RLH_OFS_FN_CTL:  nxt_r.rdata = {16'h0, r_ff.fn_ctl};
				`RLH_OFS_STATUS:  nxt_r.rdata = {2'h0, r_ff.timer, 14'h0, r_ff.fault, r_ff.st == RLH_RUN};
				`RLH_OFS_IRQ_ST:  nxt_r.rdata = {29'h0, r_ff.irq_st};
				`RLH_OFS_IRQ_CLR: nxt_r.rdata = 32'h0000_0000;
				`RLH_OFS_IRQ_EN:  nxt_r.rdata = {29'h0, r_ff.irq_en};
				default: begin
					nxt_r.rdata = 32'h0000_0000;
					nxt_r.rresp = 2'h2;
				end
			endcase
		end
		// handshake bit: a new set wins over the clear
		nxt_r.hs = r_ff.hs | hs_set;
		// supervision
		case (r_ff.st)
			RLH_IDLE: begin
				nxt_r.tcnt = 32'h0000_0000;
				if (sup) begin
					nxt_r.timer = r_ff.period;
					nxt_r.st    = RLH_RUN;
				end
			end
			RLH_RUN: begin
				nxt_r.tcnt = tick ? 32'h0000_0000 : r_ff.tcnt + 32'h0000_0001;
				if (!sup) begin
					nxt_r.st = RLH_IDLE;
				end else if (r_ff.hs) begin
					nxt_r.hs    = hs_set;
					nxt_r.timer = r_ff.period;
					nxt_r.tcnt  = 32'h0000_0000;
					nxt_r.irq_st[`RLH_IRQ_HS] = 1'b1;
				end else if (tick) begin
					if (r_ff.timer <= 14'h0001) begin
						nxt_r.st = RLH_FAULT;
						nxt_r.irq_st[`RLH_IRQ_FAULT] = 1'b1;
					end else begin
						nxt_r.timer = r_ff.timer - 14'h0001;
					end
				end
			end
			RLH_FAULT: begin
				nxt_r.tcnt = 32'h0000_0000;
				if (!r_ff.mode)
					nxt_r.st = RLH_IDLE;
			end
			default: nxt_r.st = RLH_IDLE;
		endcase
		nxt_r.fault = nxt_r.st == RLH_FAULT;
		if (nxt_r.fault) begin
			nxt_r.act    = 1'b0;
			nxt_r.hs     = 1'b0;
			nxt_r.fn_act = 16'h0000;
		end
		nxt_r.fn_remote = nxt_r.mode ? nxt_r.fn_act : 16'h0000;
		nxt_r.fn_val    = nxt_r.fn_ctl & nxt_r.fn_remote;
		nxt_r.irq       = |(nxt_r.irq_st & nxt_r.irq_en);
		nxt_r.awready   = ~nxt_r.awv;
		nxt_r.wready    = ~nxt_r.wv;
		nxt_r.arready   = ~nxt_r.rvalid;
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_ff        <= '0;
			r_ff.st     <= RLH_IDLE;
			r_ff.period <= `RLH_PERIOD_RST;
			r_ff.timer  <= `RLH_PERIOD_RST;
		end else if (ce) begin
			r_ff <= nxt_r;
		end
	end

	assign s_axi_awready = r_ff.awready;
	assign s_axi_wready  = r_ff.wready;
	assign s_axi_bvalid  = r_ff.bvalid;
	assign s_axi_bresp   = r_ff.bresp;
	assign s_axi_arready = r_ff.arready;
	assign s_axi_rvalid  = r_ff.rvalid;
	assign s_axi_rdata   = r_ff.rdata;
	assign s_axi_rresp   = r_ff.rresp;
	assign fn_remote     = r_ff.fn_remote[NFUNC-1:0];
	assign fn_value      = r_ff.fn_val[NFUNC-1:0];
	assign link_fault    = r_ff.fault;
	assign irq           = r_ff.irq;

	// ****************************************
	// checks
	// ****************************************
	property p_idle_outside_mode;
		@(posedge aclk) disable iff (!aresetn)
		(ce && r_ff.st == RLH_RUN && !r_ff.mode) |=> r_ff.st == RLH_IDLE && !r_ff.fault;
	endproperty
	a_idle_outside_mode: assert property (p_idle_outside_mode) else $error("supervision ran outside remote mode");

	property p_ctrl_write;
		@(posedge aclk) disable iff (!aresetn)
		(ce && wr_go && r_ff.awaddr == `RLH_OFS_CTRL && r_ff.wstrb[0] && r_ff.st != RLH_FAULT)
			|=> r_ff.mode == $past(r_ff.wdata[0]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("mode bit not taken from write");

	property p_period_range;
		@(posedge aclk) disable iff (!aresetn)
		r_ff.period >= `RLH_PERIOD_MIN && r_ff.period <= `RLH_PERIOD_MAX;
	endproperty
	a_period_range: assert property (p_period_range) else $error("period outside range");

	property p_hs_restart;
		@(posedge aclk) disable iff (!aresetn)
		(ce && r_ff.st == RLH_RUN && sup && r_ff.hs && !hs_set)
			|=> !r_ff.hs && r_ff.timer == $past(r_ff.period) && r_ff.tcnt == 32'h0000_0000;
	endproperty
	a_hs_restart: assert property (p_hs_restart) else $error("handshake not cleared with restart");

	property p_expiry_fault;
		@(posedge aclk) disable iff (!aresetn)
		(ce && r_ff.st == RLH_RUN && sup && !r_ff.hs && tick && r_ff.timer <= 14'h0001)
			|=> r_ff.st == RLH_FAULT ##0 link_fault;
	endproperty
	a_expiry_fault: assert property (p_expiry_fault) else $error("missed period without fault");

	property p_fault_drop;
		@(posedge aclk) disable iff (!aresetn)
		link_fault |-> fn_remote == '0 && fn_value == '0 && !r_ff.act;
	endproperty
	a_fault_drop: assert property (p_fault_drop) else $error("remote function alive during fault");

	property p_remote_select;
		@(posedge aclk) disable iff (!aresetn)
		!link_fault |-> r_ff.fn_remote == (r_ff.mode ? r_ff.fn_act : 16'h0000)
			&& r_ff.fn_val == (r_ff.fn_ctl & r_ff.fn_remote);
	endproperty
	a_remote_select: assert property (p_remote_select) else $error("remote selection mismatch");

	property p_tick_count;
		@(posedge aclk) disable iff (!aresetn)
		(ce && r_ff.st == RLH_RUN && sup && !r_ff.hs && tick && r_ff.timer > 14'h0001)
			|=> r_ff.timer == $past(r_ff.timer) - 14'h0001;
	endproperty
	a_tick_count: assert property (p_tick_count) else $error("timer did not step on tick");

endmodule // rlh_monitor

// ---- sim/rlh_peer.sv ----
`include "rlh_defs.svh"
module rlh_peer (
	// clock
	input  wire logic        aclk,
	// write channels
	output logic             awvalid,
	input  wire logic        awready,
	output logic [7:0]       awaddr,
	output logic             wvalid,
	input  wire logic        wready,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	input  wire logic        bvalid,
	output logic             bready,
	input  wire logic [1:0]  bresp,
	// read channels
	output logic             arvalid,
	input  wire logic        arready,
	output logic [7:0]       araddr,
	input  wire logic        rvalid,
	output logic             rready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, wdata, wstrb, araddr} = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		{awvalid, wvalid, bready} <= 3'h7;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		do begin
			@(posedge aclk);
			// released address and data lines stop showing the old value; wstrb stays at 4'hf
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr <= ~awaddr;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata <= ~wdata;
			end
		end while (!(bvalid && bready));
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		{arvalid, rready} <= 2'h3;
		araddr <= a;
		do begin
			@(posedge aclk);
			if (arvalid && arready) begin
				arvalid <= 1'b0;
				araddr <= ~araddr;
			end
		end while (!(rvalid && rready));
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
	endtask
	task automatic keepalive(input int n, input int gap);
		logic [1:0] r;
		repeat (n) begin
			repeat (gap) @(posedge aclk);
			wr(`RLH_OFS_HSHAKE, 32'h1, r);
		end
	endtask
endmodule // rlh_peer

// ---- sim/test_remote_link_handshake_monitor.sv ----
`include "rlh_defs.svh"
module test_remote_link_handshake_monitor;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int T = 4;
	logic        aclk, aresetn, ce, link_fault, irq;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr, fn_remote, fn_value, m_act, m_ctl;
	logic [31:0] wdata, rdata, seed, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	int          error_cnt, n_compared, per, n;
	int          pv[5] = '{9, 9990, 9991, 0, 10};
	rlh_monitor #(.NFUNC(8), .TICK_CYCLES(T)) u_dut (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.fn_remote(fn_remote), .fn_value(fn_value), .link_fault(link_fault), .irq(irq));
	rlh_peer u_peer (.aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_pin(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp(what, exp, got);
	endtask
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] rsp);
		u_peer.wr(a, v, r);
		cmp("bresp", rsp, r);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rsp);
		u_peer.rd(a, d, r);
		cmp("rdata", exp, d);
		cmp("rresp", rsp, r);
	endtask
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ****************************************
	// watchdog
	// ****************************************
	initial begin
		repeat (5000) @(posedge aclk);
		error_cnt++;
		print_verdict;
	end
	// ****************************************
	// tests
	// ****************************************
	initial begin
		{error_cnt, n_compared} = '0;
		{aresetn, ce, seed, per} = {1'b0, 1'b1, 32'hcee9, 32'd10};
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd_chk(`RLH_OFS_PERIOD, 32'ha, 2'h0);
		foreach (pv[i]) begin
			wr_chk(`RLH_OFS_PERIOD, pv[i], 2'h0);
			if (pv[i] >= 10 && pv[i] <= 9990)
				per = pv[i];
			rd_chk(`RLH_OFS_PERIOD, per, 2'h0);
		end
		chk_pin("irq", 0, irq);
		rd_chk(`RLH_OFS_IRQ_ST, 32'h4, 2'h0);
		wr_chk(`RLH_OFS_IRQ_EN, 32'h4, 2'h0);
		repeat (2) @(posedge aclk);
		chk_pin("irq", 1, irq);
		wr_chk(`RLH_OFS_IRQ_CLR, 32'h4, 2'h0);
		repeat (2) @(posedge aclk);
		chk_pin("irq", 0, irq);
		$display("test period range done");
		wr_chk(`RLH_OFS_CTRL, 32'h2, 2'h0);
		repeat (3 * per * T) @(posedge aclk);
		chk_pin("link_fault", 0, link_fault);
		// timer never loaded outside remote mode: still at its reset value
		rd_chk(`RLH_OFS_STATUS, {2'h0, `RLH_PERIOD_RST, 16'h0000}, 2'h0);
		$display("test local mode done");
		seed = lfsr(seed);
		{m_act, m_ctl} = seed[15:0];
		wr_chk(`RLH_OFS_CTRL, 32'h1, 2'h0);
		wr_chk(`RLH_OFS_FN_ACT, m_act, 2'h0);
		wr_chk(`RLH_OFS_FN_CTL, m_ctl, 2'h0);
		repeat (2) @(posedge aclk);
		chk_pin("fn_remote", m_act, fn_remote);
		chk_pin("fn_value", m_act & m_ctl, fn_value);
		$display("test remote functions done");
		wr_chk(`RLH_OFS_CTRL, 32'h3, 2'h0);
		seed = lfsr(seed);
		u_peer.keepalive(5, 20 + seed % 11);
		chk_pin("link_fault", 0, link_fault);
		rd_chk(`RLH_OFS_HSHAKE, 32'h0, 2'h0);
		rd_chk(`RLH_OFS_IRQ_ST, 32'h2, 2'h0);
		// clock enable low freezes the period timer: no expiry while frozen
		ce <= 1'b0;
		repeat (3 * per * T) @(posedge aclk);
		chk_pin("link_fault", 0, link_fault);
		ce <= 1'b1;
		wr_chk(`RLH_OFS_HSHAKE, 32'h1, 2'h0);
		repeat (per * T - 3) @(posedge aclk);
		chk_pin("link_fault", 0, link_fault);
		n = 0;
		while (link_fault !== 1'b1 && n < 12) begin
			@(posedge aclk);
			n++;
		end
		chk_pin("link_fault", 1, link_fault);
		chk_pin("fn_remote", 0, fn_remote);
		chk_pin("fn_value", 0, fn_value);
		rd_chk(`RLH_OFS_CTRL, 32'h1, 2'h0);
		rd_chk(`RLH_OFS_FN_ACT, 32'h0, 2'h0);
		wr_chk(`RLH_OFS_IRQ_EN, 32'h1, 2'h0);
		repeat (2) @(posedge aclk);
		chk_pin("irq", 1, irq);
		$display("test link fault done");
		wr_chk(8'h40, 32'h5, 2'h2);
		rd_chk(8'h40, 32'h0, 2'h2);
		wr_chk(`RLH_OFS_CTRL, 32'h0, 2'h0);
		repeat (2) @(posedge aclk);
		chk_pin("link_fault", 0, link_fault);
		$display("test unmapped and exit done");
		print_verdict;
	end
endmodule // test_remote_link_handshake_monitor
